// ===== design/pll_ctl_pkg.sv
// Notes on behaviour
// - Acquisition mode shows the filter-mode bit as zero.
// - Tracking mode whenever not acquiring or the filter-mode bit is one.
// - Automatic selection lets the lock detector switch filter modes itself.
// - Automatic: filter-mode bit read-only, follows acquisition tolerance window.
// - Automatic: settled flag read-only, follows lock tolerance.
// - Automatic: settled flag toggle raises interrupt when enabled.
// - Manual: filter-mode bit is software-written and selects the filter.
// - Manual: settled indication inactive, no interrupts.
// - Prescale power field holds P, 0 to 3, in control register.
// - Multiplier N is 12 bits split over high and low registers.
// - E in control register, L and R in their own registers.
// - P, E, N, L, R writes ignored while loop power is on.
// - Manual: settle interrupt enable forced zero, not writable.
// - Change flag sets on toggle, cleared by control read, zero manual.
package pll_ctl_pkg;
  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_BW   = 8'h04;
  localparam logic [7:0] OFS_MULH = 8'h08;
  localparam logic [7:0] OFS_MULL = 8'h0C;
  localparam logic [7:0] OFS_VRS  = 8'h10;
  localparam logic [7:0] OFS_RDIV = 8'h14;
  localparam logic [7:0] OFS_IST  = 8'h18;
  localparam logic [7:0] OFS_IMSK = 8'h1C;
  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int B_IE   = 7;
  localparam int B_FLAG = 6;
  localparam int B_ON   = 5;
  localparam int B_BCS  = 4;
  localparam int B_PRE  = 2;
  localparam int B_VPR  = 0;
  // Bandwidth register fields
  localparam int B_AUTO = 7;
  localparam int B_LOCK = 6;
  localparam int B_ACQ  = 5;
  // Interrupt status bits
  localparam int B_IST_LOCK = 0;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic        RST_ON   = 1'b1;
  localparam logic [11:0] RST_MUL  = 12'h040;
  localparam logic [7:0]  RST_VRS  = 8'h40;
  localparam logic [3:0]  RST_RDIV = 4'h1;
  localparam logic [1:0]  RESP_OK  = 2'h0;
  localparam logic [1:0]  RESP_ERR = 2'h2;
endpackage

// ===== design/sync2.sv
module sync2 (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic d_i,
  output logic      q_o
);
  logic s1_q;
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s1_q <= 1'b0;
      q_o  <= 1'b0;
    end else begin
      s1_q <= d_i;
      q_o  <= s1_q;
    end
  end
endmodule // sync2

// ===== design/pll_mode_and_divider_control.sv
module pll_mode_and_divider_control (
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        acq_window_i,
  input  wire logic        lock_window_i,
  output logic             filter_wide_narrow_o,
  output logic             loop_power_on_o,
  output logic             base_clock_choice_o,
  output logic [1:0]       prescale_power_o,
  output logic [1:0]       vco_range_power_o,
  output logic [11:0]      multiplier_o,
  output logic [7:0]       vco_linear_range_o,
  output logic [3:0]       ref_divider_o,
  output logic             irq_o
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic        auto_q, acq_q, lock_q, ie_q, flag_q;
  logic        on_q, bcs_q;
  logic [1:0]  pre_q, vpr_q;
  logic [11:0] mul_q;
  logic [7:0]  vrs_q;
  logic [3:0]  rdiv_q;
  logic        ist_q, imsk_q;
  logic        acq_s, lock_s;
  logic        aw_q, w_q;
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic        wr_go, rd_go, wmap, rmap;
  logic        toggle;
  logic [31:0] rd_d;

  // ---------------------------------------------------------------
  // Detector inputs
  // ---------------------------------------------------------------
  // Analog comparators are asynchronous to the bus clock
  sync2 u_sync_acq (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .d_i       (acq_window_i),
    .q_o       (acq_s)
  );
  sync2 u_sync_lock (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .d_i       (lock_window_i),
    .q_o       (lock_s)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite write side
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign wr_go = aw_q && w_q && !s_axi_bvalid;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q  <= 32'h0000_0000;
      wstrb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awaddr_q)
      pll_ctl_pkg::OFS_CTRL, pll_ctl_pkg::OFS_BW,
      pll_ctl_pkg::OFS_MULH, pll_ctl_pkg::OFS_MULL,
      pll_ctl_pkg::OFS_VRS,  pll_ctl_pkg::OFS_RDIV,
      pll_ctl_pkg::OFS_IST,  pll_ctl_pkg::OFS_IMSK: wmap = 1'b1;
      default: wmap = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= pll_ctl_pkg::RESP_OK;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wmap ? pll_ctl_pkg::RESP_OK : pll_ctl_pkg::RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Only byte lane 0 carries register data
  logic wr0;
  assign wr0 = wr_go && wstrb_q[0];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      on_q  <= pll_ctl_pkg::RST_ON;
      bcs_q <= 1'b0;
      pre_q <= 2'h0;
      vpr_q <= 2'h0;
      ie_q  <= 1'b0;
    end else begin
      if (!auto_q) begin
        ie_q <= 1'b0;
      end else if (wr0 && awaddr_q == pll_ctl_pkg::OFS_CTRL) begin
        ie_q <= wdata_q[pll_ctl_pkg::B_IE];
      end
      if (wr0 && awaddr_q == pll_ctl_pkg::OFS_CTRL) begin
        // Power and clock choice never change in one write
        if (bcs_q) begin
          bcs_q <= wdata_q[pll_ctl_pkg::B_BCS];
        end else if (on_q && vrs_q != 8'h00) begin
          if (wdata_q[pll_ctl_pkg::B_BCS]) begin
            bcs_q <= 1'b1;
          end else begin
            on_q <= wdata_q[pll_ctl_pkg::B_ON];
          end
        end else begin
          on_q <= wdata_q[pll_ctl_pkg::B_ON];
        end
        if (!on_q) begin
          pre_q <= wdata_q[pll_ctl_pkg::B_PRE +: 2];
          vpr_q <= wdata_q[pll_ctl_pkg::B_VPR +: 2];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Divider settings, frozen while the loop runs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      mul_q  <= pll_ctl_pkg::RST_MUL;
      vrs_q  <= pll_ctl_pkg::RST_VRS;
      rdiv_q <= pll_ctl_pkg::RST_RDIV;
    end else if (wr0 && !on_q) begin
      case (awaddr_q)
        pll_ctl_pkg::OFS_MULH: mul_q[11:8] <= wdata_q[3:0];
        pll_ctl_pkg::OFS_MULL: mul_q[7:0]  <= wdata_q[7:0];
        pll_ctl_pkg::OFS_VRS:  vrs_q       <= wdata_q[7:0];
        pll_ctl_pkg::OFS_RDIV: rdiv_q      <= wdata_q[3:0];
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Bandwidth mode and lock detection
  // ---------------------------------------------------------------
  assign toggle = auto_q && (lock_s != lock_q);

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      auto_q <= 1'b0;
      acq_q  <= 1'b0;
      lock_q <= 1'b0;
    end else begin
      if (wr0 && awaddr_q == pll_ctl_pkg::OFS_BW) begin
        auto_q <= wdata_q[pll_ctl_pkg::B_AUTO];
      end
      if (auto_q) begin
        acq_q  <= acq_s;
        lock_q <= lock_s;
      end else begin
        lock_q <= 1'b0;
        if (wr0 && awaddr_q == pll_ctl_pkg::OFS_BW) begin
          acq_q <= wdata_q[pll_ctl_pkg::B_ACQ];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock change flag and interrupts
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else if (!auto_q) begin
      flag_q <= 1'b0;
    end else if (toggle) begin
      flag_q <= 1'b1;
    end else if (rd_go && s_axi_araddr == pll_ctl_pkg::OFS_CTRL) begin
      flag_q <= 1'b0;
    end
  end

  // Set wins over write-one-clear
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ist_q  <= 1'b0;
      imsk_q <= 1'b0;
    end else begin
      if (toggle && ie_q) begin
        ist_q <= 1'b1;
      end else if (!auto_q) begin
        ist_q <= 1'b0;
      end else if (wr0 && awaddr_q == pll_ctl_pkg::OFS_IST &&
                   wdata_q[pll_ctl_pkg::B_IST_LOCK]) begin
        ist_q <= 1'b0;
      end
      if (wr0 && awaddr_q == pll_ctl_pkg::OFS_IMSK) begin
        imsk_q <= wdata_q[pll_ctl_pkg::B_IST_LOCK];
      end
    end
  end

  assign irq_o = ist_q && imsk_q && ie_q;

  // ---------------------------------------------------------------
  // AXI4-Lite read side
  // ---------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;

  always_comb begin
    rd_d = 32'h0000_0000;
    rmap = 1'b1;
    case (s_axi_araddr)
      pll_ctl_pkg::OFS_CTRL: begin
        rd_d[pll_ctl_pkg::B_IE]        = ie_q;
        rd_d[pll_ctl_pkg::B_FLAG]      = flag_q;
        rd_d[pll_ctl_pkg::B_ON]        = on_q;
        rd_d[pll_ctl_pkg::B_BCS]       = bcs_q;
        rd_d[pll_ctl_pkg::B_PRE +: 2]  = pre_q;
        rd_d[pll_ctl_pkg::B_VPR +: 2]  = vpr_q;
      end
      pll_ctl_pkg::OFS_BW: begin
        rd_d[pll_ctl_pkg::B_AUTO] = auto_q;
        rd_d[pll_ctl_pkg::B_LOCK] = lock_q;
        rd_d[pll_ctl_pkg::B_ACQ]  = acq_q;
      end
      pll_ctl_pkg::OFS_MULH: rd_d[3:0] = mul_q[11:8];
      pll_ctl_pkg::OFS_MULL: rd_d[7:0] = mul_q[7:0];
      pll_ctl_pkg::OFS_VRS:  rd_d[7:0] = vrs_q;
      pll_ctl_pkg::OFS_RDIV: rd_d[3:0] = rdiv_q;
      pll_ctl_pkg::OFS_IST:  rd_d[0]   = ist_q;
      pll_ctl_pkg::OFS_IMSK: rd_d[0]   = imsk_q;
      default: rmap = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= pll_ctl_pkg::RESP_OK;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_d;
      s_axi_rresp  <= rmap ? pll_ctl_pkg::RESP_OK : pll_ctl_pkg::RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Loop outputs
  // ---------------------------------------------------------------
  // Zero selects acquisition, one tracking
  assign filter_wide_narrow_o = acq_q;
  assign loop_power_on_o      = on_q;
  assign base_clock_choice_o  = bcs_q;
  assign prescale_power_o     = pre_q;
  assign vco_range_power_o    = vpr_q;
  assign multiplier_o         = mul_q;
  assign vco_linear_range_o   = vrs_q;
  assign ref_divider_o        = rdiv_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_toggle_en;
    toggle && ie_q;
  endsequence

  chk_lock_follow: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) auto_q && $past(auto_q) |-> lock_q == $past(lock_s))
    else $error("lock does not follow detector");
  chk_acq_follow: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) auto_q && $past(auto_q) |-> acq_q == $past(acq_s))
    else $error("acq does not follow detector");
  chk_irq_raise: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) s_toggle_en ##1 (auto_q && ie_q && imsk_q) |-> irq_o)
    else $error("toggle raised no interrupt");
  chk_manual_quiet: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) !auto_q ##1 !auto_q |-> !lock_q && !irq_o)
    else $error("manual mode shows lock or irq");
  chk_ie_forced: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) $past(!auto_q) |-> !ie_q)
    else $error("irq enable set in manual");
  chk_flag_set: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) toggle ##1 auto_q |-> flag_q)
    else $error("change flag not set");
  chk_freeze_on: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) $past(on_q) |->
      $stable(mul_q) && $stable(vrs_q) && $stable(rdiv_q) && $stable(pre_q)
      && $stable(vpr_q))
    else $error("setting changed while loop on");
  chk_mode_out: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i)
      !auto_q && wr0 && awaddr_q == pll_ctl_pkg::OFS_BW |=>
      filter_wide_narrow_o == $past(wdata_q[pll_ctl_pkg::B_ACQ]))
    else $error("filter mode output wrong");
  chk_bcs_safe: assert property (@(posedge clk_sys_i)
    disable iff (!resetn_i) bcs_q |-> on_q)
    else $error("clock chosen with loop off");
endmodule // pll_mode_and_divider_control

// ===== test/tb_pll_mode_and_divider_control.sv
module tb_pll_mode_and_divider_control;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------
  logic        clk_sys_i, resetn_i;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        arvalid, arready, rvalid, rready;
  logic        acq_win, lock_win, filt, pwr_on, base_clock_choice, irq;
  logic [1:0]  pre, vco_range_power;
  logic [11:0] mult;
  logic [7:0]  vrs;
  logic [3:0]  rdiv;
  int          error_cnt, n_tests, cyc;

  pll_mode_and_divider_control i_dut (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .acq_window_i(acq_win),
    .lock_window_i(lock_win), .filter_wide_narrow_o(filt),
    .loop_power_on_o(pwr_on), .base_clock_choice_o(base_clock_choice),
    .prescale_power_o(pre), .vco_range_power_o(vco_range_power),
    .multiplier_o(mult), .vco_linear_range_o(vrs),
    .ref_divider_o(rdiv), .irq_o(irq)
  );

  always #2.5 clk_sys_i = ~clk_sys_i;

  // Whole sequence needs well under a thousand cycles
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Channels released independently: the slave may take aw and w apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk_sys_i);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge clk_sys_i);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge clk_sys_i);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    check(nm, d, exp);
    check("rresp", 32'(r), 32'(pll_ctl_pkg::RESP_OK));
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, pll_ctl_pkg::RESP_OK);
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    clk_sys_i = 1'b0; resetn_i = 1'b0; cyc = 0;
    error_cnt = 0; n_tests = 0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hF;
    awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; acq_win = 1'b0; lock_win = 1'b0;
    cycles(10);
    resetn_i <= 1'b1;
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'h20);
    rd_chk("mull", pll_ctl_pkg::OFS_MULL, 32'h40);
    rd_chk("rdiv", pll_ctl_pkg::OFS_RDIV, 32'h01);
    rd(8'h20, d, r);
    check("unmapped resp", 32'(r), 32'(pll_ctl_pkg::RESP_ERR));
    check("unmapped data", d, 32'h0);
    wr(8'h24, 32'h1, pll_ctl_pkg::RESP_ERR);
    // Loop powered at reset, so settings must hold
    w(pll_ctl_pkg::OFS_MULL, 32'hF5);
    check("mult", 32'(mult), 32'h040);
    w(pll_ctl_pkg::OFS_CTRL, 32'h00);
    check("on", 32'(pwr_on), 32'h0);
    for (int p = 0; p < 4; p++) begin
      w(pll_ctl_pkg::OFS_CTRL, 32'(p * 4 + (p > 2 ? 2 : p)));
      check("pre", 32'(pre), 32'(p));
      check("vpr", 32'(vco_range_power), 32'(p > 2 ? 2 : p));
    end
    w(pll_ctl_pkg::OFS_MULH, 32'hFF);
    w(pll_ctl_pkg::OFS_MULL, 32'hFF);
    check("mult", 32'(mult), 32'hFFF);
    rd_chk("mulh", pll_ctl_pkg::OFS_MULH, 32'h0F);
    w(pll_ctl_pkg::OFS_MULH, 32'h01);
    w(pll_ctl_pkg::OFS_MULL, 32'h2C);
    w(pll_ctl_pkg::OFS_VRS, 32'h80);
    w(pll_ctl_pkg::OFS_RDIV, 32'hF3);
    // Write without byte lane 0 must leave the setting alone
    wstrb <= 4'hE;
    w(pll_ctl_pkg::OFS_VRS, 32'h11);
    wstrb <= 4'hF;
    check("mult", 32'(mult), 32'h12C);
    check("vrs", 32'(vrs), 32'h80);
    rd_chk("rdiv", pll_ctl_pkg::OFS_RDIV, 32'h03);
    // Power on with filter still wide, then try every setting
    w(pll_ctl_pkg::OFS_CTRL, 32'h2E);
    w(pll_ctl_pkg::OFS_CTRL, 32'h20);
    w(pll_ctl_pkg::OFS_MULL, 32'h00);
    w(pll_ctl_pkg::OFS_MULH, 32'h00);
    w(pll_ctl_pkg::OFS_VRS, 32'h00);
    w(pll_ctl_pkg::OFS_RDIV, 32'h00);
    check("pre", 32'(pre), 32'h3);
    check("vpr", 32'(vco_range_power), 32'h2);
    check("mult", 32'(mult), 32'h12C);
    check("vrs", 32'(vrs), 32'h80);
    check("rdiv", 32'(rdiv), 32'h3);
    // Manual mode
    cycles(20);
    w(pll_ctl_pkg::OFS_BW, 32'h20);
    check("filt", 32'(filt), 32'h1);
    cycles(20);
    w(pll_ctl_pkg::OFS_CTRL, 32'h3E);
    check("bcs", 32'(base_clock_choice), 32'h1);
    w(pll_ctl_pkg::OFS_CTRL, 32'hBE);
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'h3E);
    lock_win <= 1'b1;
    cycles(5);
    rd_chk("bw", pll_ctl_pkg::OFS_BW, 32'h20);
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'h3E);
    check("irq", 32'(irq), 32'h0);
    w(pll_ctl_pkg::OFS_BW, 32'h00);
    check("filt", 32'(filt), 32'h0);
    lock_win <= 1'b0;
    cycles(5);
    // Automatic mode
    w(pll_ctl_pkg::OFS_BW, 32'h80);
    acq_win <= 1'b1;
    cycles(5);
    check("filt", 32'(filt), 32'h1);
    w(pll_ctl_pkg::OFS_BW, 32'h80);
    check("filt", 32'(filt), 32'h1);
    acq_win <= 1'b0;
    cycles(5);
    check("filt", 32'(filt), 32'h0);
    w(pll_ctl_pkg::OFS_CTRL, 32'hBE);
    w(pll_ctl_pkg::OFS_IMSK, 32'h1);
    lock_win <= 1'b1;
    cycles(5);
    rd_chk("bw", pll_ctl_pkg::OFS_BW, 32'hC0);
    check("irq", 32'(irq), 32'h1);
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'hFE);
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'hBE);
    rd_chk("ist", pll_ctl_pkg::OFS_IST, 32'h1);
    w(pll_ctl_pkg::OFS_IST, 32'h1);
    check("irq", 32'(irq), 32'h0);
    // Masked event stays pending until unmasked
    w(pll_ctl_pkg::OFS_IMSK, 32'h0);
    lock_win <= 1'b0;
    cycles(5);
    check("irq", 32'(irq), 32'h0);
    rd_chk("ist", pll_ctl_pkg::OFS_IST, 32'h1);
    w(pll_ctl_pkg::OFS_IMSK, 32'h1);
    check("irq", 32'(irq), 32'h1);
    // Back to manual with an event pending
    w(pll_ctl_pkg::OFS_BW, 32'h00);
    // Enable and status drop one edge after the mode write lands
    cycles(1);
    check("irq", 32'(irq), 32'h0);
    rd_chk("ctrl", pll_ctl_pkg::OFS_CTRL, 32'h3E);
    report_and_stop();
  end
endmodule // tb_pll_mode_and_divider_control
